// [sfr_top.v]
/*
 * receive flag logic and ninth-bit handling of an asynchronous serial
 * interface. characters come from a receive shifter through a two-entry
 * buffer; flags, ninth bits and interrupt requests are plain ports.
 * the buffer is drained every cycle, so overrun is judged against the
 * rx full flag alone; a lost character leaves no trace apart from the
 * overrun flag. the transmit side covers only the data buffer and its
 * hand-over to an external shifter, not the serial framing itself.
 * error and idle detection happen upstream; this block only keeps
 * their flags and the order in which software may clear them.
 * assumes software accesses are one-cycle strobes on CLK_SYS and that
 * the receive pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.vh"
module sfr_top #(
    parameter DATA_W = 8
) (
    // clock and asynchronous reset
    input  wire              CLK_SYS,
    input  wire              RESETN,
    // receive pin and mode levels
    input  wire              RXD_PIN,
    input  wire              RX_ON_SELECT,
    input  wire              NINE_BIT_MODE,
    // character word from the receive shifter
    input  wire              RX_CHAR_VALID,
    output wire              RX_CHAR_READY,
    input  wire [DATA_W-1:0] RX_CHAR_DATA,
    input  wire              RX_CHAR_NINTH,
    input  wire              RX_CHAR_NOISE,
    input  wire              RX_CHAR_FRAMING,
    input  wire              RX_CHAR_PARITY,
    input  wire              RX_LINE_IDLE,
    // software read and write strobes
    input  wire              STATUS_RD,
    input  wire              DATA_RD,
    input  wire              DATA_WR,
    input  wire [DATA_W-1:0] DATA_WDATA,
    input  wire              TX_NINTH_WR,
    input  wire              TX_NINTH_WDATA,
    input  wire              EDGE_FLAG_WR,
    input  wire              EDGE_FLAG_WDATA,
    // local interrupt enables
    input  wire              TX_EMPTY_IRQ_EN,
    input  wire              TX_DONE_IRQ_EN,
    input  wire              RX_FULL_IRQ_EN,
    input  wire              IDLE_IRQ_EN,
    input  wire              ERROR_IRQ_EN,
    input  wire              EDGE_IRQ_EN,
    // transmit shifter hand-over
    input  wire              TX_SHIFT_READY,
    output reg               TX_SHIFT_LOAD,
    output reg  [DATA_W:0]   TX_SHIFT_DATA,
    output reg               TX_NINE_BIT,
    // status, data and control three read-back
    output reg  [7:0]        STATUS_ONE,
    output reg  [DATA_W-1:0] RX_DATA,
    output wire [7:0]        CONTROL_THREE,
    output wire              RX_EDGE_FLAG,
    // interrupt requests, plain levels
    output wire              TX_IRQ,
    output wire              RX_IRQ,
    output wire              ERR_IRQ
);
    // word width: data plus ninth, parity, framing and noise bits
    localparam BW = DATA_W + 4;

    // buffered receive word: error bits, ninth bit, data
    wire [BW-1:0] buf_in;
    wire [BW-1:0] buf_out;
    wire          buf_valid;
    wire          buf_take;

    assign buf_in = {RX_CHAR_NOISE, RX_CHAR_FRAMING, RX_CHAR_PARITY,
                     RX_CHAR_NINTH, RX_CHAR_DATA};

    // a stalled source never loses a word: ready drops only when both
    // entries are occupied
    sfr_skid #(
        .WIDTH    (BW)
    ) u_buf (
        .clk      (CLK_SYS),
        .resetn   (RESETN),
        .in_valid (RX_CHAR_VALID),
        .in_ready (RX_CHAR_READY),
        .in_data  (buf_in),
        .out_valid(buf_valid),
        .out_ready(buf_take),
        .out_data (buf_out)
    );

    // transmit flags
    reg tx_empty_flag_r;
    reg tx_done_flag_r;

    // receive flags
    reg rx_full_flag_r;
    reg idle_flag_r;
    reg overrun_flag_r;
    reg noise_flag_r;
    reg framing_error_flag_r;
    reg parity_error_flag_r;
    reg rx_edge_flag_r;

    // ninth bits kept in control three
    reg rx_ninth_bit_r;
    reg tx_ninth_bit_r;

    // idle rearm and the status-read half of each clear
    reg idle_armed_r;
    reg full_seen_r;
    reg idle_seen_r;

    // transmit data buffer between software and shifter
    reg [DATA_W-1:0] tx_buf_r;

    // pin synchroniser, then edge detector on the second stage
    reg rxd_meta_r;
    reg rxd_sync_r;
    reg rxd_prev_r;
    wire rxd_fall;
    // stages reset to the line's idle level, so no false edge after reset

    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rxd_meta_r <= 1'b1;
            rxd_sync_r <= 1'b1;
            rxd_prev_r <= 1'b1;
        end else begin
            rxd_meta_r <= RXD_PIN;
            rxd_sync_r <= rxd_meta_r;
            rxd_prev_r <= rxd_sync_r;
        end
    end

    // only the second stage and its delayed copy are read; the first
    // stage may still be settling
    // falling edge is active
    assign rxd_fall = rxd_prev_r & ~rxd_sync_r & RX_ON_SELECT;

    // no stall towards the buffer: the flag logic takes a word each cycle
    // a buffered character is always drained; overrun decides its fate
    assign buf_take = buf_valid;

    // second step of a clear: a data read after an armed status read
    function clr_step;
        input data_rd;
        input seen;
        begin
            clr_step = data_rd & seen;
        end
    endfunction

    // clear qualifiers: status read while flag set, then a data read
    // a data read without the status step clears nothing
    wire rx_full_clr;
    wire idle_clr;
    assign rx_full_clr = clr_step(DATA_RD, full_seen_r);
    assign idle_clr    = clr_step(DATA_RD, idle_seen_r);

    wire char_in;
    wire char_lost;
    assign char_in   = buf_take & ~rx_full_flag_r;
    assign char_lost = buf_take & rx_full_flag_r;

    // receive flags, data and ninth bit
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_full_flag_r       <= 1'b0;
            idle_flag_r          <= 1'b0;
            overrun_flag_r       <= 1'b0;
            noise_flag_r         <= 1'b0;
            framing_error_flag_r <= 1'b0;
            parity_error_flag_r  <= 1'b0;
            rx_ninth_bit_r       <= 1'b0;
            idle_armed_r         <= 1'b1;
            full_seen_r          <= 1'b0;
            idle_seen_r          <= 1'b0;
            RX_DATA              <= `SFR_DATA_RST;
        end else begin
            // arm status-read step; a new set after it still needs a read
            if (STATUS_RD) begin
                full_seen_r <= rx_full_flag_r;
                idle_seen_r <= idle_flag_r;
            end else if (DATA_RD) begin
                full_seen_r <= 1'b0;
                idle_seen_r <= 1'b0;
            end

            if (char_in) begin
                rx_full_flag_r       <= 1'b1;
                noise_flag_r         <= buf_out[DATA_W+3];
                framing_error_flag_r <= buf_out[DATA_W+2];
                parity_error_flag_r  <= buf_out[DATA_W+1];
                rx_ninth_bit_r       <= NINE_BIT_MODE & buf_out[DATA_W];
                RX_DATA              <= buf_out[DATA_W-1:0];
                // a new character rearms idle detection
                idle_armed_r         <= 1'b1;
            end else if (rx_full_clr) begin
                // errors leave together with the character
                rx_full_flag_r       <= 1'b0;
                noise_flag_r         <= 1'b0;
                framing_error_flag_r <= 1'b0;
                parity_error_flag_r  <= 1'b0;
            end

            // a lost word is never stored, so its error bits never reach
            // the flags
            // lost character keeps error flags
            if (char_lost) begin
                overrun_flag_r <= 1'b1;
            end else if (rx_full_clr) begin
                overrun_flag_r <= 1'b0;
            end

            // a set flag is not set again, so a still idle line cannot
            // override the clear that software has completed
            // idle rearmed only by a new character
            if (RX_LINE_IDLE & idle_armed_r & ~idle_flag_r & ~char_in) begin
                idle_flag_r  <= 1'b1;
            end else if (idle_clr) begin
                idle_flag_r  <= 1'b0;
                idle_armed_r <= 1'b0;
            end
        end
    end

    // an edge in the same cycle as a clearing write wins, so no edge is
    // ever missed
    // write one clears, set wins
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rx_edge_flag_r <= 1'b0;
        end else if (rxd_fall) begin
            rx_edge_flag_r <= 1'b1;
        end else if (EDGE_FLAG_WR & EDGE_FLAG_WDATA) begin
            rx_edge_flag_r <= 1'b0;
        end
    end

    // transmit buffer and shifter load
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tx_empty_flag_r <= 1'b1;
            tx_done_flag_r  <= 1'b1;
            tx_ninth_bit_r  <= 1'b0;
            tx_buf_r        <= `SFR_DATA_RST;
            TX_SHIFT_LOAD   <= 1'b0;
            TX_SHIFT_DATA   <= {(DATA_W+1){1'b0}};
        end else begin
            TX_SHIFT_LOAD <= 1'b0;
            if (TX_NINTH_WR) begin
                tx_ninth_bit_r <= TX_NINTH_WDATA;
            end
            // a write while the buffer is full overwrites it; software
            // polls tx empty first
            if (DATA_WR) begin
                tx_buf_r        <= DATA_WDATA;
                tx_empty_flag_r <= 1'b0;
                tx_done_flag_r  <= 1'b0;
            end else if (~tx_empty_flag_r & TX_SHIFT_READY) begin
                TX_SHIFT_LOAD   <= 1'b1;
                TX_SHIFT_DATA   <= {tx_ninth_bit_r & NINE_BIT_MODE,
                                    tx_buf_r};
                tx_empty_flag_r <= 1'b1;
            end else if (tx_empty_flag_r & TX_SHIFT_READY &
                         ~TX_SHIFT_LOAD) begin
                // done needs an empty buffer and no load still in flight
                tx_done_flag_r  <= 1'b1;
            end
        end
    end

    // registered so the shifter sees a clean level; the receive ninth
    // bit is masked in the receive path when eight-bit mode is chosen
    // character length to both directions
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            TX_NINE_BIT <= 1'b0;
        end else begin
            TX_NINE_BIT <= NINE_BIT_MODE;
        end
    end

    // registered copy keeps the read-back word glitch free; it lags
    // the flags by one clock
    // status readable regardless of enables
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            STATUS_ONE <= `SFR_STATUS_RST;
        end else begin
            STATUS_ONE <= {tx_empty_flag_r, tx_done_flag_r,
                           rx_full_flag_r, idle_flag_r, overrun_flag_r,
                           noise_flag_r, framing_error_flag_r,
                           parity_error_flag_r};
        end
    end

    // bits five to zero are unused and read back as zero
    // ninth bits in control three, other bits zero
    assign CONTROL_THREE = {rx_ninth_bit_r, tx_ninth_bit_r, 6'h00};
    assign RX_EDGE_FLAG  = rx_edge_flag_r;

    // plain levels: a request falls as soon as its flag or enable
    // goes low; there is no interrupt logic beyond this gating
    // flag and enable gate requests
    assign TX_IRQ  = (tx_empty_flag_r & TX_EMPTY_IRQ_EN) |
                     (tx_done_flag_r & TX_DONE_IRQ_EN);
    assign RX_IRQ  = (rx_full_flag_r & RX_FULL_IRQ_EN) |
                     (idle_flag_r & IDLE_IRQ_EN) |
                     (rx_edge_flag_r & EDGE_IRQ_EN);
    assign ERR_IRQ = ERROR_IRQ_EN & (overrun_flag_r | noise_flag_r |
                     framing_error_flag_r | parity_error_flag_r);
endmodule
`default_nettype wire

// [sfr_regs.vh]
/*
 * constants for the serial receive flag block: status bit positions,
 * control bit positions and reset values.
 * assumes it is included by bare name from the block's design files.
 */
`ifndef SFR_REGS_VH
`define SFR_REGS_VH

// status one bit positions
`define SFR_ST_TX_EMPTY   7
`define SFR_ST_TX_DONE    6
`define SFR_ST_RX_FULL    5
`define SFR_ST_IDLE       4
`define SFR_ST_OVERRUN    3
`define SFR_ST_NOISE      2
`define SFR_ST_FRAMING    1
`define SFR_ST_PARITY     0

// control three bit positions
`define SFR_C3_RX_NINTH   7
`define SFR_C3_TX_NINTH   6

// reset values and buffer depth
`define SFR_STATUS_RST    8'hC0
`define SFR_DATA_RST      8'h00
`define SFR_BUF_DEPTH     2

`endif

// [sfr_skid.v]
/*
 * two-entry buffer with valid and ready on both sides.
 * assumes one clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sfr_skid #(
    parameter WIDTH = 12
) (
    input  wire             clk,
    input  wire             resetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:1];
    reg             wr_ptr_r;
    reg             rd_ptr_r;
    reg [1:0]       count_r;
    wire            push;
    wire            pop;

    // full at two; ready goes low so the source stalls
    assign in_ready  = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data  = mem_r[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // storage write, no reset needed on data
    always @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and occupancy
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop & ~push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [sfr_chk.sv]
/* port checker for the serial receive flag block.
   assumes it is bound to sfr_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.vh"
module sfr_chk #(
    parameter DATA_W = 8
) (
    input wire logic              CLK_SYS,
    input wire logic              RESETN,
    input wire logic              RXD_PIN,
    input wire logic              RX_ON_SELECT,
    input wire logic              NINE_BIT_MODE,
    input wire logic              DATA_RD,
    input wire logic              EDGE_FLAG_WR,
    input wire logic              EDGE_FLAG_WDATA,
    input wire logic              TX_SHIFT_LOAD,
    input wire logic [DATA_W:0]   TX_SHIFT_DATA,
    input wire logic              TX_NINE_BIT,
    input wire logic [7:0]        STATUS_ONE,
    input wire logic [7:0]        CONTROL_THREE,
    input wire logic              RX_EDGE_FLAG
);
    // one domain; reset low disables every check
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // edge flag: gated by enable, set by a fall, cleared by a one
    property p_edge_off; !$past(RX_ON_SELECT) && !$past(RX_ON_SELECT, 2)
        |-> !$rose(RX_EDGE_FLAG); endproperty
    a_edge_off: assert property (p_edge_off)
        else $error("edge flag rose while receiver off");
    property p_edge_set; $fell(RXD_PIN) && RX_ON_SELECT
        |-> ##[1:4] RX_EDGE_FLAG; endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("edge flag missed a falling edge");
    property p_edge_clr; EDGE_FLAG_WR && EDGE_FLAG_WDATA && !RX_ON_SELECT
        && !$past(RX_ON_SELECT) |=> !RX_EDGE_FLAG; endproperty
    a_edge_clr: assert property (p_edge_clr)
        else $error("edge flag not cleared by a one");

    // status lags the flags by one edge, so a clear shows two edges on
    property p_full_clr; $fell(STATUS_ONE[`SFR_ST_RX_FULL])
        |-> $past(DATA_RD, 2); endproperty
    a_full_clr: assert property (p_full_clr)
        else $error("rx full cleared without data read");
    property p_idle_clr; $fell(STATUS_ONE[`SFR_ST_IDLE])
        |-> $past(DATA_RD, 2); endproperty
    a_idle_clr: assert property (p_idle_clr)
        else $error("idle cleared without data read");
    property p_err; $rose(STATUS_ONE[`SFR_ST_NOISE])
        |-> $rose(STATUS_ONE[`SFR_ST_RX_FULL]); endproperty
    a_err: assert property (p_err)
        else $error("noise flag apart from rx full");
    property p_ovr; $rose(STATUS_ONE[`SFR_ST_OVERRUN])
        |-> STATUS_ONE[`SFR_ST_RX_FULL] && $stable(STATUS_ONE[2:0]);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("overrun without full or with new errors");

    // transmit side: length copy and ninth bit travelling with data
    property p_nine; TX_NINE_BIT == $past(NINE_BIT_MODE); endproperty
    a_nine: assert property (p_nine)
        else $error("length bit not passed on");
    property p_tx9; TX_SHIFT_LOAD
        |-> TX_SHIFT_DATA[DATA_W] == CONTROL_THREE[`SFR_C3_TX_NINTH];
    endproperty
    a_tx9: assert property (p_tx9)
        else $error("ninth bit not loaded with data");
endmodule
bind sfr_top sfr_chk #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// [sfr_rx_model.sv]
/* receive shifter model: hands words over valid/ready and pulls the
   pin low for each start bit. assumes one caller at a time. */
`timescale 1ns/1ps
`default_nettype none
module sfr_rx_model (
    input  wire logic        clk,
    input  wire logic        ready,
    output var  logic        valid,
    output var  logic [11:0] word,
    output var  logic        rxd
);
    // line idles high
    initial {rxd, valid, word} = 14'h2000;
    // word held until taken; released data shows its inverse
    task automatic send(input logic [11:0] w);
        @(negedge clk);
        {rxd, valid, word} = {2'b01, w};
        while (ready !== 1'b1) @(negedge clk);
        @(negedge clk);
        {rxd, valid, word} = {2'b10, ~w};
    endtask
endmodule
`default_nettype wire

// [sfr_tb.sv]
/* self-checking bench for sfr_top with a receive shifter model.
   assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`default_nettype none
`include "sfr_regs.vh"
module testbench;
    logic CLK_SYS, RESETN, RX_ON_SELECT, NINE_BIT_MODE, RX_LINE_IDLE;
    logic STATUS_RD, DATA_RD, DATA_WR, TX_NINTH_WR, TX_NINTH_WDATA;
    logic EDGE_FLAG_WR, EDGE_FLAG_WDATA, TX_SHIFT_READY, ERROR_IRQ_EN;
    logic TX_EMPTY_IRQ_EN, TX_DONE_IRQ_EN, RX_FULL_IRQ_EN;
    logic IDLE_IRQ_EN, EDGE_IRQ_EN;
    logic [7:0] DATA_WDATA, d;
    logic [8:0] rq[$], tq[$];
    int error_cnt = 0, cmp_count = 0, seed = 18987, i;
    wire logic RXD_PIN, RX_CHAR_VALID, RX_CHAR_READY, RX_CHAR_NINTH;
    wire logic RX_CHAR_NOISE, RX_CHAR_FRAMING, RX_CHAR_PARITY;
    wire logic TX_SHIFT_LOAD, TX_NINE_BIT, RX_EDGE_FLAG;
    wire logic TX_IRQ, RX_IRQ, ERR_IRQ;
    wire logic [7:0] RX_CHAR_DATA, STATUS_ONE, RX_DATA, CONTROL_THREE;
    wire logic [8:0] TX_SHIFT_DATA;
    wire logic [11:0] w;

    sfr_top uut (.*);
    sfr_rx_model pm (.clk(CLK_SYS), .ready(RX_CHAR_READY),
        .valid(RX_CHAR_VALID), .word(w), .rxd(RXD_PIN));
    // word: parity, framing, noise, ninth, data
    assign {RX_CHAR_PARITY, RX_CHAR_FRAMING, RX_CHAR_NOISE, RX_CHAR_NINTH,
        RX_CHAR_DATA} = w;

    task automatic chk(input string n, input logic [8:0] s, e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic finish_test;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK_SYS);
    endtask
    // strobe for one edge, then a quiet edge so no double assignment
    task automatic pulse(ref logic s);
        s = 1;
        cyc(1);
        s = 0;
        cyc(1);
    endtask
    task automatic wait_bit(input int b, input logic v);
        for (int k = 0; k < 50 && STATUS_ONE[b] !== v; k++) cyc(1);
        chk("status bit", STATUS_ONE[b], v);
    endtask
    task automatic rd_char;
        pulse(STATUS_RD);
        pulse(DATA_RD);
    endtask

    initial begin
        CLK_SYS = 0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    // generous cap: the whole run needs only about a hundred cycles
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
    // each data read returns the oldest noted character
    always @(posedge CLK_SYS)
        if (DATA_RD && rq.size() > 0)
            chk("rx char", {CONTROL_THREE[7], RX_DATA}, rq.pop_front());
    always @(posedge CLK_SYS)
        if (TX_SHIFT_LOAD === 1'b1)
            chk("tx load", TX_SHIFT_DATA, tq.pop_front());

    initial begin
        {RX_ON_SELECT, NINE_BIT_MODE, RX_LINE_IDLE, STATUS_RD, DATA_RD} = 0;
        {DATA_WR, TX_NINTH_WR, TX_NINTH_WDATA, EDGE_FLAG_WR} = 0;
        {EDGE_FLAG_WDATA, TX_EMPTY_IRQ_EN, TX_DONE_IRQ_EN} = 0;
        {RX_FULL_IRQ_EN, IDLE_IRQ_EN, EDGE_IRQ_EN, ERROR_IRQ_EN} = 4'hD;
        {DATA_WDATA, TX_SHIFT_READY, RESETN} = 10'h002;
        cyc(5);
        RESETN = 1;
        cyc(2);
        chk("status reset", STATUS_ONE, `SFR_STATUS_RST);
        chk("tx irq", TX_IRQ, 0);
        NINE_BIT_MODE = 1;
        cyc(2);
        chk("length", TX_NINE_BIT, 1);
        // noisy char; a lone data read must not clear it
        d = $random(seed);
        repeat (2) rq.push_back({1'b1, d});
        pm.send({4'h3, d});
        wait_bit(`SFR_ST_RX_FULL, 1);
        chk("errors", STATUS_ONE[2:0], 3'b100);
        chk("irqs", {RX_IRQ, ERR_IRQ, RX_EDGE_FLAG}, 3'b110);
        pulse(DATA_RD);
        chk("kept", STATUS_ONE[`SFR_ST_RX_FULL], 1);
        rd_char;
        wait_bit(`SFR_ST_RX_FULL, 0);
        // second char while full is lost with its framing error
        RX_ON_SELECT = 1;
        d = $random(seed);
        rq.push_back({1'b0, d});
        pm.send({4'h0, d});
        wait_bit(`SFR_ST_RX_FULL, 1);
        pm.send({4'h4, ~d});
        wait_bit(`SFR_ST_OVERRUN, 1);
        chk("lost errors", STATUS_ONE[2:0], 0);
        chk("edge", RX_EDGE_FLAG, 1);
        rd_char;
        wait_bit(`SFR_ST_RX_FULL, 0);
        pulse(EDGE_FLAG_WR);
        chk("edge zero", RX_EDGE_FLAG, 1);
        RX_ON_SELECT = 0;
        EDGE_FLAG_WDATA = 1;
        cyc(2);
        pulse(EDGE_FLAG_WR);
        chk("edge one", RX_EDGE_FLAG, 0);
        // idle clears and stays clear until a new character
        RX_LINE_IDLE = 1;
        wait_bit(`SFR_ST_IDLE, 1);
        rd_char;
        wait_bit(`SFR_ST_IDLE, 0);
        cyc(20);
        chk("idle held", STATUS_ONE[`SFR_ST_IDLE], 0);
        RX_LINE_IDLE = 0;
        d = $random(seed);
        rq.push_back({1'b1, d});
        pm.send({4'h1, d});
        wait_bit(`SFR_ST_RX_FULL, 1);
        rd_char;
        RX_LINE_IDLE = 1;
        wait_bit(`SFR_ST_IDLE, 1);
        // transmit: ninth written before data, kept when not rewritten
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            if (!i[0]) begin
                TX_NINTH_WDATA = ~i[1];
                pulse(TX_NINTH_WR);
            end
            tq.push_back({~i[1], d});
            TX_SHIFT_READY = 0;
            DATA_WDATA = d;
            pulse(DATA_WR);
            TX_SHIFT_READY = 1;
            for (int k = 0; k < 50 && tq.size() > 0; k++) cyc(1);
        end
        cyc(3);
        chk("tx flags", STATUS_ONE[7:6], 2'b11);
        TX_DONE_IRQ_EN = 1;
        cyc(1);
        chk("tx irq", TX_IRQ, 1);
        finish_test;
    end
endmodule
`default_nettype wire
